// >>> rtl/pcc_pkg.sv
// Package holding register map, field layout, reset values and types of the PLL calibration and sync control.
package pcc_pkg;

   // Register offsets in the control port address space.
   localparam logic [9:0] LOCK_CAL_CTRL_ADDR   = 10'h018;
   localparam logic [9:0] ALIGN_DELAY_ADDR     = 10'h019;
   localparam logic [9:0] UPDATE_ADDR          = 10'h232;

   // Field positions in the lock and calibration control register.
   localparam int TUNE_DIV_LSB      = 1;
   localparam int TUNE_TRIG_BIT     = 0;
   // Field positions in the align and path delay register.
   localparam int ALIGN_ACT_LSB     = 6;
   localparam int REF_DELAY_LSB     = 3;
   localparam int FB_DELAY_LSB      = 0;
   // Update bit position in the update register.
   localparam int UPDATE_BIT        = 0;

   // Reset values; divider code 11 selects divide by 16.
   localparam logic [7:0] LOCK_CAL_CTRL_RST = 8'h06;
   localparam logic [7:0] ALIGN_DELAY_RST   = 8'h00;

   // Align action codes.
   typedef enum logic [1:0] {
      ALIGN_NONE  = 2'h0,
      ALIGN_ASYNC = 2'h1,
      ALIGN_SYNC  = 2'h2,
      ALIGN_NONE2 = 2'h3
   } pcc_align_type;

   // Decoded active settings handed to the analog side.
   typedef struct packed {
      logic [1:0] tuneClockDivider;
      logic [2:0] referenceBranchDelay;
      logic [2:0] feedbackBranchDelay;
      logic [1:0] dividerCounterAlignAction;
   } pcc_settings_type;

   // Write request from the serial control port.
   typedef struct packed {
      logic       wrEn;
      logic [9:0] addr;
      logic [7:0] data;
   } pcc_write_type;

endpackage : pcc_pkg

// >>> rtl/pcc_cal_clock_div.sv
// Divider that derives the calibration clock enable from the reference clock tick.
`timescale 1ns/1ps
module pcc_cal_clock_div (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       refTick,
   input  wire logic [1:0] divCode,
   output logic            calTick
);

   logic [3:0] count_ff;
   logic [3:0] nxt_count;
   logic       calTick_ff;
   logic       nxt_calTick;

   // Terminal count for ratios 2, 4, 8 and 16.
   function automatic logic [3:0] divLimit(input logic [1:0] code);
      divLimit = 4'((5'h02 << code) - 5'h01);
   endfunction : divLimit

   // Count reference ticks and pulse once per full ratio.
   always_comb begin
      nxt_count   = count_ff;
      nxt_calTick = 1'b0;
      if (refTick) begin
         if (count_ff >= divLimit(divCode)) begin
            nxt_count   = 4'h0;
            nxt_calTick = 1'b1;
         end else begin
            nxt_count = count_ff + 4'h1;
         end
      end
   end

   // Register the divider state.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         count_ff   <= 4'h0;
         calTick_ff <= 1'b0;
      end else begin
         count_ff   <= nxt_count;
         calTick_ff <= nxt_calTick;
      end
   end

   assign calTick = calTick_ff;

endmodule : pcc_cal_clock_div

// >>> rtl/pcc_ctrl.sv
// Top of the PLL calibration trigger, divider select, counter align and path delay control.
//
// Function
// - Calibration clock is reference divided by 2, 4, 8 or 16; default 16.
// - Calibration starts only on a 0-to-1 of the active trigger bit.
// - Written values reach active registers only when the update bit is written.
// - Align pin: code 01 async counter reset, 10 sync reset, 00/11 nothing.
//
// Host writes land in buffer registers and only move to the active set when the update bit is
// written, so a group of fields always changes together at one clock edge.
// Readback shows the buffers, which lets software check a pending value before it commits it.
// The reference clock and the align pin are asynchronous and pass two flip-flops first.
`timescale 1ns/1ps
module pcc_ctrl (
   input  wire logic                      mclk,
   input  wire logic                      rst_n,
   input  wire pcc_pkg::pcc_write_type    wrReq,
   input  wire logic [9:0]                rdAddr,
   input  wire logic                      refClkIn,
   input  wire logic                      alignRequestPin,
   output logic [7:0]                     rdData,
   output pcc_pkg::pcc_settings_type      activeSettings,
   output logic                           calStart,
   output logic                           calClkTick,
   output logic                           counterAsyncReset,
   output logic                           counterSyncReset
);

   // Buffer images written by the host, and the active images that steer hardware.
   logic [7:0]                lockCalBuf_ff;
   logic [7:0]                nxt_lockCalBuf;
   logic [7:0]                alignBuf_ff;
   logic [7:0]                nxt_alignBuf;
   logic [7:0]                lockCalAct_ff;
   logic [7:0]                nxt_lockCalAct;
   logic [7:0]                alignAct_ff;
   logic [7:0]                nxt_alignAct;
   // Calibration start pulse and readback registers.
   logic                      calStart_ff;
   logic                      nxt_calStart;
   logic [7:0]                rdData_ff;
   logic [7:0]                nxt_rdData;
   // Pin synchronisers; only the second and third stages feed logic.
   logic [2:0]                refSync_ff;
   logic [2:0]                nxt_refSync;
   logic [2:0]                alignSync_ff;
   logic [2:0]                nxt_alignSync;
   // Counter reset outputs.
   logic                      asyncRst_ff;
   logic                      nxt_asyncRst;
   logic                      syncRst_ff;
   logic                      nxt_syncRst;
   // Decoded strobes and pin events.
   logic                      refTick;
   logic                      alignRise;
   logic                      updateHit;
   logic                      lockCalHit;
   logic                      alignHit;
   logic                      calTickInt;
   pcc_pkg::pcc_align_type    alignAction;

   // True when the write strobe targets the given register address.
   function automatic logic wrHit(input pcc_pkg::pcc_write_type req, input logic [9:0] addr);
      wrHit = req.wrEn && (req.addr == addr);
   endfunction : wrHit

   // Calibration trigger bit of a lock and calibration control image.
   function automatic logic trigOf(input logic [7:0] image);
      trigOf = image[pcc_pkg::TUNE_TRIG_BIT];
   endfunction : trigOf

   // Calibration clock divider code of a lock and calibration control image.
   function automatic logic [1:0] divOf(input logic [7:0] image);
      divOf = image[pcc_pkg::TUNE_DIV_LSB +: 2];
   endfunction : divOf

   // Three-bit path delay field of an align and delay image, found at the given position.
   function automatic logic [2:0] delayOf(input logic [7:0] image, input int lsb);
      delayOf = image[lsb +: 3];
   endfunction : delayOf

   // Counter align action field of an align and delay image.
   function automatic logic [1:0] actionOf(input logic [7:0] image);
      actionOf = image[pcc_pkg::ALIGN_ACT_LSB +: 2];
   endfunction : actionOf

   // Write decode; an update with its bit clear is ignored.
   assign lockCalHit = wrHit(wrReq, pcc_pkg::LOCK_CAL_CTRL_ADDR);
   assign alignHit   = wrHit(wrReq, pcc_pkg::ALIGN_DELAY_ADDR);
   assign updateHit  = wrHit(wrReq, pcc_pkg::UPDATE_ADDR) && wrReq.data[pcc_pkg::UPDATE_BIT];

   // Buffer registers take host writes; they do not steer hardware.
   // A write and an update in one cycle commit the value held before that write.
   always_comb begin
      nxt_lockCalBuf = lockCalBuf_ff;
      nxt_alignBuf   = alignBuf_ff;
      if (lockCalHit) begin
         nxt_lockCalBuf = wrReq.data;
      end
      if (alignHit) begin
         nxt_alignBuf = wrReq.data;
      end
   end

   // Active registers load from buffers only on update.
   // The trigger edge is judged against the active value that this update replaces.
   always_comb begin
      nxt_lockCalAct = lockCalAct_ff;
      nxt_alignAct   = alignAct_ff;
      nxt_calStart   = 1'b0;
      if (updateHit) begin
         nxt_lockCalAct = lockCalBuf_ff;
         nxt_alignAct   = alignBuf_ff;
         // A held 1 gives no new start.
         nxt_calStart   = trigOf(lockCalBuf_ff) && !trigOf(lockCalAct_ff);
      end
   end

   // Readback returns the buffered values written by the host.
   // Reads are registered, so data follows the address by one cycle.
   always_comb begin
      case (rdAddr)
         pcc_pkg::LOCK_CAL_CTRL_ADDR: nxt_rdData = lockCalBuf_ff;
         pcc_pkg::ALIGN_DELAY_ADDR:   nxt_rdData = alignBuf_ff;
         default:                     nxt_rdData = 8'h00;
      endcase
   end

   // Register the configuration state.
   // Buffers and active images both return to their reset values.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         lockCalBuf_ff <= pcc_pkg::LOCK_CAL_CTRL_RST;
         alignBuf_ff   <= pcc_pkg::ALIGN_DELAY_RST;
         lockCalAct_ff <= pcc_pkg::LOCK_CAL_CTRL_RST;
         alignAct_ff   <= pcc_pkg::ALIGN_DELAY_RST;
         calStart_ff   <= 1'b0;
         rdData_ff     <= 8'h00;
      end else begin
         lockCalBuf_ff <= nxt_lockCalBuf;
         alignBuf_ff   <= nxt_alignBuf;
         lockCalAct_ff <= nxt_lockCalAct;
         alignAct_ff   <= nxt_alignAct;
         calStart_ff   <= nxt_calStart;
         rdData_ff     <= nxt_rdData;
      end
   end

   // Two-flop synchronisers plus a third stage for edge detection.
   // The pins are asynchronous, so nothing but the second stage reads the first.
   always_comb begin
      nxt_refSync   = {refSync_ff[1:0], refClkIn};
      nxt_alignSync = {alignSync_ff[1:0], alignRequestPin};
   end

   // Register the synchroniser stages; the align pin idles low, as the reset value does.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         refSync_ff   <= 3'h0;
         alignSync_ff <= 3'h0;
      end else begin
         refSync_ff   <= nxt_refSync;
         alignSync_ff <= nxt_alignSync;
      end
   end

   // Edge detect on settled samples and decode of the active align action.
   assign refTick     = refSync_ff[1] && !refSync_ff[2];
   assign alignRise   = alignSync_ff[1] && !alignSync_ff[2];
   assign alignAction = pcc_pkg::pcc_align_type'(actionOf(alignAct_ff));

   // Counter reset: async holds while pin is high, sync pulses on its rise.
   // Codes 00 and 11 leave both outputs low whatever the pin does.
   always_comb begin
      nxt_asyncRst = 1'b0;
      nxt_syncRst  = 1'b0;
      case (alignAction)
         pcc_pkg::ALIGN_ASYNC: nxt_asyncRst = alignSync_ff[1];
         pcc_pkg::ALIGN_SYNC:  nxt_syncRst  = alignRise;
         default: begin
            nxt_asyncRst = 1'b0;
            nxt_syncRst  = 1'b0;
         end
      endcase
   end

   // Register the counter reset outputs.
   // The async reset therefore trails the synchronised pin by one clock.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         asyncRst_ff <= 1'b0;
         syncRst_ff  <= 1'b0;
      end else begin
         asyncRst_ff <= nxt_asyncRst;
         syncRst_ff  <= nxt_syncRst;
      end
   end

   // Calibration clock divider driven by the active divider code.
   // A code change acts at the next reference tick; a count at or past the new limit wraps and pulses on that tick.
   pcc_cal_clock_div u_div (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .refTick (refTick),
      .divCode (divOf(lockCalAct_ff)),
      .calTick (calTickInt)
   );

   // Outputs straight from flip-flops.
   // The settings fields are slices of the active images, so they change only on update.
   assign rdData                                   = rdData_ff;
   assign calStart                                 = calStart_ff;
   assign calClkTick                               = calTickInt;
   assign counterAsyncReset                        = asyncRst_ff;
   assign counterSyncReset                         = syncRst_ff;
   assign activeSettings.tuneClockDivider          = divOf(lockCalAct_ff);
   assign activeSettings.referenceBranchDelay      = delayOf(alignAct_ff, pcc_pkg::REF_DELAY_LSB);
   assign activeSettings.feedbackBranchDelay       = delayOf(alignAct_ff, pcc_pkg::FB_DELAY_LSB);
   assign activeSettings.dividerCounterAlignAction = actionOf(alignAct_ff);

endmodule : pcc_ctrl

// >>> tb/pcc_ctrl_assertions.sv
// Checker of the PLL calibration and sync control ports.
`timescale 1ns/1ps
module pcc_ctrl_assertions (
   input wire logic                      mclk,
   input wire logic                      rst_n,
   input wire pcc_pkg::pcc_write_type    wrReq,
   input wire logic [9:0]                rdAddr,
   input wire logic                      alignRequestPin,
   input wire logic [7:0]                rdData,
   input wire pcc_pkg::pcc_settings_type activeSettings,
   input wire logic                      calStart,
   input wire logic                      calClkTick,
   input wire logic                      counterAsyncReset,
   input wire logic                      counterSyncReset
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Update strobe and active align action.
   wire logic       upd = wrReq.wrEn && wrReq.addr == pcc_pkg::UPDATE_ADDR && wrReq.data[0];
   wire logic [1:0] act = activeSettings.dividerCounterAlignAction;
   // Align pin rises while the synchronous action is active.
   sequence s_pin_rise;
      $rose(alignRequestPin) && act == 2'h2;
   endsequence
   AST_CAL_CAUSE: assert property (calStart |-> $past(upd)) else $error("calStart without update");
   AST_CAL_PULSE: assert property (calStart |=> !calStart) else $error("calStart too long");
   AST_SET_HOLD: assert property (!$past(upd) |-> $stable(activeSettings)) else $error("settings moved");
   AST_SYNC_CAUSE: assert property (s_pin_rise |-> ##[2:5] counterSyncReset) else $error("no sync reset");
   AST_SYNC_PULSE: assert property (counterSyncReset |=> !counterSyncReset) else $error("sync too long");
   AST_ASYNC_ACT: assert property (counterAsyncReset |-> $past(act) == 2'h1) else $error("async wrong code");
   AST_TICK_GAP: assert property (calClkTick |=> !calClkTick [*7]) else $error("ticks too close");
   AST_RD_ZERO: assert property (!($past(rdAddr) inside {10'h018, 10'h019}) |-> rdData == 8'h00)
      else $error("unmapped read not zero");
endmodule : pcc_ctrl_assertions

// >>> tb/pcc_host_model.sv
// Host model that writes control registers through the write port.
`timescale 1ns/1ps
module pcc_host_model (
   input  wire logic             mclk,
   output pcc_pkg::pcc_write_type wrReq
);
   initial wrReq = '0;
   // One-cycle write strobe launched at the falling edge.
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(negedge mclk) wrReq = {1'b1, a, d};
      @(negedge mclk) wrReq = '0;
   endtask : wr
   // Write a register, then commit it with the update bit.
   task automatic commit(input logic [9:0] a, input logic [7:0] d);
      wr(a, d);
      wr(pcc_pkg::UPDATE_ADDR, 8'h01);
   endtask : commit
   // Trigger is committed at 0 before it is committed at 1.
   task automatic calibrate(input logic [7:0] d);
      commit(pcc_pkg::LOCK_CAL_CTRL_ADDR, d & 8'hFE);
      commit(pcc_pkg::LOCK_CAL_CTRL_ADDR, d | 8'h01);
   endtask : calibrate
endmodule : pcc_host_model

// >>> tb/pcc_ctrl_tb_top.sv
// Self-checking bench of the PLL calibration and sync control.
`timescale 1ns/1ps
module pcc_ctrl_tb_top;
   logic                      mclk, rst_n, refClkIn, alignRequestPin, calStart, calClkTick;
   logic                      counterAsyncReset, counterSyncReset;
   logic [9:0]                rdAddr;
   logic [7:0]                rdData, v;
   pcc_pkg::pcc_write_type    wrReq;
   pcc_pkg::pcc_settings_type activeSettings;
   int                        miscompares = 0, n_tests = 0, g;
   int                        notes[$];
   pcc_host_model host_u (.mclk(mclk), .wrReq(wrReq));
   pcc_ctrl dut_u (.mclk(mclk), .rst_n(rst_n), .wrReq(wrReq), .rdAddr(rdAddr), .refClkIn(refClkIn),
      .alignRequestPin(alignRequestPin), .rdData(rdData), .activeSettings(activeSettings), .calStart(calStart),
      .calClkTick(calClkTick), .counterAsyncReset(counterAsyncReset), .counterSyncReset(counterSyncReset));
   // System clock and an 80 ns reference, slower than a quarter of it.
   initial begin
      mclk = 0;
      refClkIn = 0;
      fork
         forever #5 mclk = ~mclk;
         forever #40 refClkIn = ~refClkIn;
      join
   end
   // Counts and reports one comparison.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input logic [9:0] a, input logic [7:0] e);
      @(negedge mclk) rdAddr = a;
      @(negedge mclk) chk({8'h00, rdData}, {8'h00, e});
   endtask : rd
   task automatic rst();
      @(negedge mclk) rst_n = 0;
      repeat (2) @(negedge mclk);
      rst_n = 1;
      chk({6'h00, activeSettings}, 16'h0300);
   endtask : rst
   // Cycles between two calibration ticks.
   task automatic gapOf();
      repeat (300) if (!calClkTick) @(negedge mclk);
      g = 1;
      @(negedge mclk);
      while (!calClkTick && g < 300) begin
         @(negedge mclk);
         g++;
      end
   endtask : gapOf
   function automatic logic [7:0] nextRand(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : nextRand
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude
   // Each result pulse takes the oldest note off the queue.
   always @(negedge mclk) if (rst_n && (calStart || counterSyncReset)) begin
      chk({14'h0000, counterSyncReset, calStart}, 16'(notes.size() ? notes.pop_front() : 0));
   end
   // Cuts a hang short.
   initial begin
      #300us;
      miscompares++;
      conclude();
   end
   // Main sequence of scenarios.
   initial begin
      rst_n = 0;
      rdAddr = 10'h000;
      alignRequestPin = 0;
      v = 8'h3F;
      rst();
      rd(10'h018, 8'h06);
      rd(10'h232, 8'h00);
      rd(10'h3FF, 8'h00);
      for (int c = 0; c < 4; c++) begin
         host_u.commit(10'h018, 8'(c << 1));
         chk({14'h0000, activeSettings.tuneClockDivider}, 16'(c));
         gapOf();
         gapOf();
         chk(16'(g), 16'(16 << c));
      end
      host_u.wr(10'h018, 8'h00);
      chk({14'h0000, activeSettings.tuneClockDivider}, 16'h0003);
      rd(10'h018, 8'h00);
      $display("Test divider done");
      repeat (2) begin
         notes.push_back(1);
         host_u.calibrate(8'h06);
      end
      host_u.wr(10'h232, 8'h01);
      host_u.wr(10'h018, 8'h03);
      host_u.wr(10'h232, 8'h00);
      chk({14'h0000, activeSettings.tuneClockDivider}, 16'h0003);
      host_u.wr(10'h018, 8'h07);
      $display("Test calibration done");
      repeat (4) begin
         v = nextRand(v);
         host_u.commit(10'h019, v);
         chk({6'h00, activeSettings}, {6'h00, 2'h3, v[5:0], v[7:6]});
         rd(10'h019, v);
      end
      for (int c = 0; c < 4; c++) begin
         host_u.commit(10'h019, 8'(c << 6));
         if (c == 2) notes.push_back(2);
         @(negedge mclk) alignRequestPin = 1;
         repeat (6) @(negedge mclk);
         chk({15'h0000, counterAsyncReset}, 16'(c == 1));
         alignRequestPin = 0;
         repeat (6) @(negedge mclk);
      end
      $display("Test align done");
      rst();
      chk(16'(notes.size()), 16'h0000);
      $display("Test reset done");
      conclude();
   end
endmodule : pcc_ctrl_tb_top
bind pcc_ctrl pcc_ctrl_assertions chk_u (.mclk(mclk), .rst_n(rst_n), .wrReq(wrReq), .rdAddr(rdAddr),
   .alignRequestPin(alignRequestPin), .rdData(rdData), .activeSettings(activeSettings), .calStart(calStart),
   .calClkTick(calClkTick), .counterAsyncReset(counterAsyncReset), .counterSyncReset(counterSyncReset));
